// ---- design/tpi_pkg.sv ----
// Purpose: constants for the twisted-pair phy interrupt and status block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   printed offsets are register indices; byte address is 4x index
package tpi_pkg;
   // ---------------------------------------------------------------
   // register indices and byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0]  IDX_INT_FLAGS_MASKS = 8'hd1;
   localparam logic [7:0]  IDX_EXT_STATUS      = 8'hd2;
   localparam logic [7:0]  IDX_P2_CONTROL      = 8'hd7;
   localparam logic [11:0] ADDR_INT_FLAGS_MASKS = 12'h344;
   localparam logic [11:0] ADDR_EXT_STATUS      = 12'h348;
   localparam logic [11:0] ADDR_P2_CONTROL      = 12'h35c;

   // ---------------------------------------------------------------
   // interrupt register fields
   // ---------------------------------------------------------------
   localparam int INT_GLOBAL_MASK_BIT  = 13;
   localparam int INT_SPEED_MASK_BIT   = 10;
   localparam int INT_DUPLEX_MASK_BIT  = 9;
   localparam int INT_LINK_MASK_BIT    = 8;
   localparam int INT_PWR_ENABLE_BIT   = 7;
   localparam int INT_PWR_FLAG_BIT     = 6;
   localparam int INT_SUMMARY_BIT      = 5;
   localparam int INT_SPEED_FLAG_BIT   = 2;
   localparam int INT_DUPLEX_FLAG_BIT  = 1;
   localparam int INT_LINK_FLAG_BIT    = 0;
   localparam logic [15:0] INT_RESET   = 16'h2700;

   // ---------------------------------------------------------------
   // extended status fields
   // ---------------------------------------------------------------
   localparam int ST_SPEED_BIT    = 14;
   localparam int ST_DUPLEX_BIT   = 13;
   localparam int ST_RESOLVED_BIT = 11;
   localparam int ST_LINK_BIT     = 10;
   localparam int ST_CROSS_BIT    = 9;
   localparam int ST_POLARITY_BIT = 8;
   localparam int ST_JABBER_BIT   = 7;
   localparam logic [15:0] ST_RESET = 16'h4008;

   // ---------------------------------------------------------------
   // second port control fields
   // ---------------------------------------------------------------
   localparam int P2_SPEED_BIT  = 13;
   localparam int P2_ANEG_BIT   = 12;
   localparam int P2_DUPLEX_BIT = 8;
   localparam logic [15:0] P2_RESET    = 16'h2100;
   localparam logic [15:0] P2_WR_MASK  = 16'hedff;
endpackage

// ---- design/tpi_change_det.sv ----
// Purpose: flags a change of a level in the same cycle, against the sample taken at the edge before
// Assumes: input synchronous to pclk
// Notes:   first sample after reset is taken silently
`timescale 1ns/1ps
`default_nettype none
module tpi_change_det (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic level_in,
   output logic      changed
);
   logic prev_reg;
   logic armed_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg  <= 1'b0;
         armed_reg <= 1'b0;
      end else begin
         prev_reg  <= level_in;
         armed_reg <= 1'b1;
      end
   end

   // no event for the first sample, so reset value never fakes a change
   assign changed = armed_reg && (prev_reg != level_in);
endmodule
`default_nettype wire

// ---- design/tpi_top.sv ----
// Purpose: interrupt flags, masks and extended status of the tp phy
// Assumes: status inputs synchronous to pclk; apb slave, zero wait
// Notes:   flags clear on a read of the interrupt register
//
// Functional notes
// - speed-change mask bit 10 blocks flag bit 2; resets to 1
// - duplex-change mask bit 9 blocks flag bit 1; resets to 1
// - link-change mask bit 8 blocks flag bit 0; resets to 1
// - power-abnormal enable bit 7: 1 passes flag bit 6; resets to 0
// - remote power-abnormal frame sets flag bit 6; cleared by read
// - summary bit 5 is OR of flag bits 0 to 4; resets to 0
// - speed change sets flag bit 2; cleared by read
// - duplex change sets flag bit 1; cleared by read
// - link change sets flag bit 0; cleared by read
// - status bit 14 shows speed, 1 = 100M
// - status bit 13 shows duplex, 1 = full
// - status bit 11 shows auto-negotiation complete
// - status bit 10 shows link up
// - status bit 9 shows crossover active
// - status bit 8 shows reversed receive polarity
// - status bit 7 shows jabber detected
// - extended status is read-only, resets to 0x4008
// - second port control has no auto-negotiation; fixed config
// - global mask bit 13 suppresses every source; resets to 1
`timescale 1ns/1ps
`default_nettype none
module tpi_top
   import tpi_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              tp_speed_100,
   input  wire logic              tp_full_duplex,
   input  wire logic              tp_aneg_done,
   input  wire logic              tp_link_up,
   input  wire logic              tp_crossed,
   input  wire logic              tp_polarity_rev,
   input  wire logic              tp_jabber,
   input  wire logic              remote_pwr_abnormal,
   output logic                   irq,
   output logic                   p2_speed_100,
   output logic                   p2_full_duplex
);
   initial begin
      if (ADDR_W < 10 || ADDR_W > 32)
         $error("tpi_top: ADDR_W must lie in 10..32");
   end

   // ---------------------------------------------------------------
   // change detection
   // ---------------------------------------------------------------
   logic speed_chg;
   logic duplex_chg;
   logic link_chg;

   tpi_change_det u_speed (
      .pclk     (pclk),
      .presetn  (presetn),
      .level_in (tp_speed_100),
      .changed  (speed_chg)
   );
   tpi_change_det u_duplex (
      .pclk     (pclk),
      .presetn  (presetn),
      .level_in (tp_full_duplex),
      .changed  (duplex_chg)
   );
   tpi_change_det u_link (
      .pclk     (pclk),
      .presetn  (presetn),
      .level_in (tp_link_up),
      .changed  (link_chg)
   );

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   logic acc;
   logic hit_int;
   logic hit_st;
   logic hit_p2;
   logic wr_int;
   logic wr_p2;
   logic rd_int;
   logic lo_en;
   logic hi_en;

   assign acc     = psel && penable;
   // cast, not part-select: a wider bus must zero-extend the offsets
   assign hit_int = (paddr == ADDR_W'(ADDR_INT_FLAGS_MASKS));
   assign hit_st  = (paddr == ADDR_W'(ADDR_EXT_STATUS));
   assign hit_p2  = (paddr == ADDR_W'(ADDR_P2_CONTROL));
   assign lo_en   = pstrb[0];
   assign hi_en   = pstrb[1];
   assign wr_int  = acc && pwrite && hit_int;
   assign wr_p2   = acc && pwrite && hit_p2;
   assign rd_int  = acc && !pwrite && hit_int;

   // ---------------------------------------------------------------
   // masks
   // ---------------------------------------------------------------
   logic global_mask_reg;
   logic speed_mask_reg;
   logic duplex_mask_reg;
   logic link_mask_reg;
   logic pwr_enable_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_mask_reg <= INT_RESET[INT_GLOBAL_MASK_BIT];
         speed_mask_reg  <= INT_RESET[INT_SPEED_MASK_BIT];
         duplex_mask_reg <= INT_RESET[INT_DUPLEX_MASK_BIT];
         link_mask_reg   <= INT_RESET[INT_LINK_MASK_BIT];
         pwr_enable_reg  <= INT_RESET[INT_PWR_ENABLE_BIT];
      end else if (wr_int) begin
         if (hi_en) begin
            global_mask_reg <= pwdata[INT_GLOBAL_MASK_BIT];
            speed_mask_reg  <= pwdata[INT_SPEED_MASK_BIT];
            duplex_mask_reg <= pwdata[INT_DUPLEX_MASK_BIT];
            link_mask_reg   <= pwdata[INT_LINK_MASK_BIT];
         end
         if (lo_en) begin
            pwr_enable_reg <= pwdata[INT_PWR_ENABLE_BIT];
         end
      end
   end

   // ---------------------------------------------------------------
   // event flags: a new event in the read cycle survives the clear
   // ---------------------------------------------------------------
   logic speed_flag_reg;
   logic duplex_flag_reg;
   logic link_flag_reg;
   logic pwr_flag_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_flag_reg  <= 1'b0;
         duplex_flag_reg <= 1'b0;
         link_flag_reg   <= 1'b0;
         pwr_flag_reg    <= 1'b0;
      end else begin
         speed_flag_reg  <= speed_chg  || (speed_flag_reg  && !rd_int);
         duplex_flag_reg <= duplex_chg || (duplex_flag_reg && !rd_int);
         link_flag_reg   <= link_chg   || (link_flag_reg   && !rd_int);
         pwr_flag_reg    <= remote_pwr_abnormal
                            || (pwr_flag_reg && !rd_int);
      end
   end

   logic summary;
   logic irq_next;

   // positions 3 and 4 are reserved and always zero
   assign summary = speed_flag_reg || duplex_flag_reg
                    || link_flag_reg;

   always_comb begin
      irq_next = 1'b0;
      if (!global_mask_reg) begin
         irq_next = (speed_flag_reg  && !speed_mask_reg)
                 || (duplex_flag_reg && !duplex_mask_reg)
                 || (link_flag_reg   && !link_mask_reg)
                 || (pwr_flag_reg    && pwr_enable_reg);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_next;
      end
   end

   // ---------------------------------------------------------------
   // second port control: speed and duplex by configuration only
   // ---------------------------------------------------------------
   logic [15:0] p2_ctrl_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p2_ctrl_reg <= P2_RESET;
      end else if (wr_p2) begin
         if (lo_en) begin
            p2_ctrl_reg[7:0] <= pwdata[7:0] & P2_WR_MASK[7:0];
         end
         if (hi_en) begin
            // auto-negotiation enable stays zero on this port
            p2_ctrl_reg[15:8] <= pwdata[15:8] & P2_WR_MASK[15:8];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p2_speed_100   <= P2_RESET[P2_SPEED_BIT];
         p2_full_duplex <= P2_RESET[P2_DUPLEX_BIT];
      end else begin
         p2_speed_100   <= p2_ctrl_reg[P2_SPEED_BIT];
         p2_full_duplex <= p2_ctrl_reg[P2_DUPLEX_BIT];
      end
   end

   // ---------------------------------------------------------------
   // extended status, registered mirror of the phy state
   // ---------------------------------------------------------------
   logic [15:0] ext_status_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_status_reg <= ST_RESET;
      end else begin
         ext_status_reg                  <= 16'h0000;
         ext_status_reg[ST_SPEED_BIT]    <= tp_speed_100;
         ext_status_reg[ST_DUPLEX_BIT]   <= tp_full_duplex;
         ext_status_reg[ST_RESOLVED_BIT] <= tp_aneg_done;
         ext_status_reg[ST_LINK_BIT]     <= tp_link_up;
         ext_status_reg[ST_CROSS_BIT]    <= tp_crossed;
         ext_status_reg[ST_POLARITY_BIT] <= tp_polarity_rev;
         ext_status_reg[ST_JABBER_BIT]   <= tp_jabber;
      end
   end

   // ---------------------------------------------------------------
   // read data and answer
   // ---------------------------------------------------------------
   logic [15:0] int_view;

   always_comb begin
      int_view                      = 16'h0000;
      int_view[INT_GLOBAL_MASK_BIT] = global_mask_reg;
      int_view[INT_SPEED_MASK_BIT]  = speed_mask_reg;
      int_view[INT_DUPLEX_MASK_BIT] = duplex_mask_reg;
      int_view[INT_LINK_MASK_BIT]   = link_mask_reg;
      int_view[INT_PWR_ENABLE_BIT]  = pwr_enable_reg;
      int_view[INT_PWR_FLAG_BIT]    = pwr_flag_reg;
      int_view[INT_SUMMARY_BIT]     = summary;
      int_view[INT_SPEED_FLAG_BIT]  = speed_flag_reg;
      int_view[INT_DUPLEX_FLAG_BIT] = duplex_flag_reg;
      int_view[INT_LINK_FLAG_BIT]   = link_flag_reg;
   end

   // registered answer: a setup cycle loads data, the access cycle ends
   logic setup;
   assign setup = psel && !penable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !(hit_int || hit_st || hit_p2);
         if (setup && !pwrite) begin
            if (hit_int) begin
               prdata <= {16'h0000, int_view};
            end else if (hit_st) begin
               prdata <= {16'h0000, ext_status_reg};
            end else if (hit_p2) begin
               prdata <= {16'h0000, p2_ctrl_reg};
            end else begin
               prdata <= 32'h0000_0000;
            end
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/tpi_chk.sv ----
// Purpose: port assertions for the tp phy interrupt and status block
// Assumes: zero-wait apb; mask bits shadowed from bus writes
// Notes:   a status read answers with inputs seen two edges earlier
`timescale 1ns/1ps
`default_nettype none
module tpi_chk
   import tpi_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              irq,
   input wire logic              tp_speed_100,
   input wire logic              tp_full_duplex,
   input wire logic              tp_aneg_done,
   input wire logic              tp_link_up,
   input wire logic              tp_crossed,
   input wire logic              tp_polarity_rev,
   input wire logic              tp_jabber,
   input wire logic              remote_pwr_abnormal
);
   logic g_m, s_m, d_m, l_m, p_en;
   wire logic rd = pready && !pwrite && !pslverr;
   wire logic at_int = paddr == ADDR_W'(ADDR_INT_FLAGS_MASKS);
   wire logic rd_int = rd && at_int;
   wire logic rd_st = rd && paddr == ADDR_W'(ADDR_EXT_STATUS);
   wire logic rd_p2 = rd && paddr == ADDR_W'(ADDR_P2_CONTROL);
   wire logic wr_int = psel && penable && pwrite && pready && at_int;
   wire logic closed = g_m || ({s_m, d_m, l_m} == 3'b111 && !p_en);
   // shadow lags nothing: the design takes the write on the same edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         {g_m, s_m, d_m, l_m, p_en} <= 5'b11110;
      else if (wr_int) begin
         if (pstrb[1])
            {g_m, s_m, d_m, l_m} <= {pwdata[13], pwdata[10:8]};
         if (pstrb[0])
            p_en <= pwdata[7];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_sum_or: assert property (rd_int |-> prdata[5] == |prdata[4:0])
      else $error("summary bit is not the or of flags");
   a_irq_closed: assert property (closed && $past(closed) |-> !irq)
      else $error("irq with every source masked");
   a_lnk_irq: assert property ($changed(tp_link_up) && !g_m && !l_m |-> ##[1:4] irq)
      else $error("link change gave no irq");
   a_dup_irq: assert property ($changed(tp_full_duplex) && !g_m && !d_m |-> ##[1:4] irq)
      else $error("duplex change gave no irq");
   a_spd_irq: assert property ($changed(tp_speed_100) && !g_m && !s_m |-> ##[1:4] irq)
      else $error("speed change gave no irq");
   a_pwr_irq: assert property (remote_pwr_abnormal && !g_m && p_en |-> ##[1:4] irq)
      else $error("power abnormal gave no irq");
   a_st_mode: assert property (rd_st |-> prdata[14:13] == $past({tp_speed_100, tp_full_duplex}, 2))
      else $error("status speed or duplex wrong");
   a_st_link: assert property (rd_st |-> prdata[11:10] == $past({tp_aneg_done, tp_link_up}, 2))
      else $error("status resolve or link wrong");
   a_st_pair: assert property (rd_st |-> prdata[9:7] == $past({tp_crossed, tp_polarity_rev, tp_jabber}, 2))
      else $error("status crossover, polarity or jabber wrong");
   a_st_resvd: assert property (rd_st |-> !prdata[15] && !prdata[12])
      else $error("status reserved bit set");
   a_p2_fixed: assert property (rd_p2 |-> !prdata[12] && !prdata[9])
      else $error("second port offers negotiation");
   c_sum: cover property (rd_int && prdata[5]);
   c_irq: cover property (irq ##1 !irq);
   c_open: cover property (wr_int && !pwdata[13]);
endmodule
bind tpi_top tpi_chk #(.ADDR_W(ADDR_W)) i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
   .tp_speed_100(tp_speed_100), .tp_full_duplex(tp_full_duplex),
   .tp_aneg_done(tp_aneg_done), .tp_link_up(tp_link_up),
   .tp_crossed(tp_crossed), .tp_polarity_rev(tp_polarity_rev),
   .tp_jabber(tp_jabber), .remote_pwr_abnormal(remote_pwr_abnormal));
`default_nettype wire

// ---- verif/tpi_apb_host.sv ----
// Purpose: management host model, apb master
// Assumes: one transfer at a time
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module tpi_apb_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb
);
   initial
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
      @(posedge pclk);
      penable <= 1'b1;
      // no wait count assumed; only the bench watchdog ends this
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
   endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Purpose: self-checking bench for tpi_top
// Assumes: status inputs change only at rising edges
// Notes:   reads note expectations; a monitor compares at pready
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tpi_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        pwr = 1'b0;
   logic [6:0]  st = 7'h40;
   logic        psel, penable, pwrite, pready, pslverr, irq, p2_s, p2_d;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [32:0] eq[$];
   logic [31:0] mq[$];
   logic [15:0] wv, fl;
   int          num_errors = 0;
   int          check_count = 0;
   always #5 pclk = ~pclk;
   tpi_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tp_speed_100(st[6]), .tp_full_duplex(st[5]), .tp_aneg_done(st[4]),
      .tp_link_up(st[3]), .tp_crossed(st[2]), .tp_polarity_rev(st[1]),
      .tp_jabber(st[0]), .remote_pwr_abnormal(pwr), .irq(irq),
      .p2_speed_100(p2_s), .p2_full_duplex(p2_d));
   tpi_apb_host i_host (.pclk(pclk), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
   function automatic logic [15:0] sx(input logic [6:0] s);
      return {1'b0, s[6:5], 1'b0, s[4:0], 7'h0};
   endfunction
   task chk(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task rd(input logic [11:0] a, input logic [15:0] e,
           input logic [15:0] m, input logic err);
      logic [31:0] q;
      logic        x;
      eq.push_back({err, 16'h0, e & m});
      mq.push_back({16'hffff, m});
      i_host.xfer(1'b0, a, 32'h0, 4'h0, q, x);
   endtask
   task wr(input logic [11:0] a, input logic [15:0] d);
      logic [31:0] q;
      logic        x;
      i_host.xfer(1'b1, a, {16'($urandom), d}, 4'h3, q, x);
   endtask
   task results;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // upper half of every answer must read zero
   always @(posedge pclk) begin
      if (pready === 1'b1 && pwrite === 1'b0)
         chk({pslverr, prdata & mq.pop_front()}, eq.pop_front());
   end
   initial begin
      repeat (5000) @(posedge pclk);
      num_errors++;
      results;
   end
   initial begin
      void'($urandom(35));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_INT_FLAGS_MASKS, INT_RESET, 16'hffff, 1'b0);
      rd(ADDR_EXT_STATUS, sx(st), 16'hff80, 1'b0);
      rd(ADDR_P2_CONTROL, P2_RESET, 16'hffff, 1'b0);
      rd(12'h100, 16'h0, 16'hffff, 1'b1);
      chk({31'h0, p2_s, p2_d}, 33'h3);
      $display("test reset done");
      wr(ADDR_EXT_STATUS, 16'hffff);
      rd(ADDR_EXT_STATUS, sx(st), 16'hff80, 1'b0);
      wr(ADDR_P2_CONTROL, 16'hffff);
      rd(ADDR_P2_CONTROL, P2_WR_MASK, 16'hffff, 1'b0);
      wr(ADDR_P2_CONTROL, 16'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, p2_s, p2_d}, 33'h0);
      $display("test writes done");
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         st <= 7'($urandom);
         repeat (3) @(posedge pclk);
         rd(ADDR_EXT_STATUS, sx(st), 16'hff80, 1'b0);
      end
      // random changes above latched masked flags: clear them
      rd(ADDR_INT_FLAGS_MASKS, INT_RESET, 16'hff00, 1'b0);
      $display("test status done");
      for (int i = 0; i < 4; i++) begin
         wv = (i == 3) ? 16'h0780 : 16'h0700 & ~(16'h0100 << i);
         fl = (i == 3) ? 16'h0040 : (16'h0001 << i) | 16'h0020;
         for (int j = 0; j < 2; j++) begin
            wv[13] = j[0];
            wr(ADDR_INT_FLAGS_MASKS, wv);
            @(posedge pclk);
            if (i == 3)
               pwr <= 1'b1;
            else
               st <= st ^ (7'h08 << i + (i > 0));
            @(posedge pclk);
            pwr <= 1'b0;
            repeat (3) @(posedge pclk);
            chk({32'h0, irq}, 33'(j == 0));
            rd(ADDR_INT_FLAGS_MASKS, wv | fl, 16'hffff, 1'b0);
            rd(ADDR_INT_FLAGS_MASKS, wv, 16'hffff, 1'b0);
            repeat (2) @(posedge pclk);
            chk({32'h0, irq}, 33'h0);
         end
      end
      $display("test events done");
      results;
   end
endmodule
`default_nettype wire
